// File: rdr_spi_direct.sv
// Serial register port with slave select and direct-mode control of the reader.
// Assumes sclk comes from the master, ssN is the slave-select pin, and the
// protocol engine sits on clock and drives the tx, rx and decoder inputs.
//
// Overview of operation
// - High slave-select holds the serial logic in reset and ends transactions.
// - Master changes MOSI on rising SCLK; device samples it on falling SCLK.
// - Every word is eight bits, most significant bit first, both directions.
// - After eighth falling edge of a read command, data appears on MISO.
// - Each read byte shifts out over eight edges, MSB first.
// - Top bit picks command or address; then read bit, continuous bit, five-bit code.
// - Transmit done raises interrupt; status read then returns the tx done value.
// - FIFO reset command empties the FIFO and clears its count.
// - Direct select bit zero: modulation from pin, raw subcarrier on receive pin.
// - Direct select bit one: decoded bits and bit clock out, modulation from pin.
// - Framed mode passes only raw data bytes through the 127-byte FIFO.
// - Writing the direct bit enters direct operation at once, even mid-session.
// - Slave-select rising leaves direct mode and clears the direct bit.
// - Direct mode 0 blocks register, FIFO and interrupt service.
`timescale 1ns/1ns
`default_nettype none
module rdr_spi_direct #(
  parameter int DEPTH = rdr_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic ssN,
  input wire logic mosi,
  output logic misoOut,
  output logic misoOe,
  input wire logic modulationInputPin,
  input wire logic modulationTypeSelect,
  input wire logic subcarrierIn,
  input wire logic decBitIn,
  input wire logic decClkIn,
  input wire logic protoModIn,
  input wire logic txDoneIn,
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  output logic modDrive,
  output logic modTypeOut,
  output logic rxDataOut,
  output logic bitClkOut,
  output logic irqOut,
  output logic directActive,
  output logic [6:0] fifoCount
);
  // Link domain: everything below up to the system section runs on falling SCLK.
  wire logic sclkFall = ~sclk;
  logic linkRst;
  logic [2:0] bitCnt_ff;
  logic [6:0] shift_ff;
  rdr_pkg::rdr_ph_t phase_ff;
  logic [4:0] addr_ff;
  logic rdMode_ff;
  logic cont_ff;
  logic [7:0] txShift_ff;
  logic evReady;
  logic snapValid;
  rdr_pkg::rdr_snap_t snapLink;

  // Read mux over the published state; narrower fields read zero above.
  function automatic logic [7:0] readReg(input rdr_pkg::rdr_snap_t s, input logic [4:0] a);
    case (a)
      rdr_pkg::ADR_CHIP: readReg = s.chip;
      rdr_pkg::ADR_ISO: readReg = s.iso;
      rdr_pkg::ADR_MODR: readReg = s.modr;
      rdr_pkg::ADR_IRQ: readReg = s.irq;
      rdr_pkg::ADR_FSTAT: readReg = {1'b0, s.fcnt};
      rdr_pkg::ADR_FIFO: readReg = s.fhead;
      default: readReg = 8'h00;
    endcase
  endfunction

  // The link side reset follows the system reset; it needs SCLK edges to apply.
  rdr_sync2 #(.W(1)) uLinkRst (.clock(sclkFall), .rst(1'b0), .din(rst), .dout(linkRst));

  // Byte assembly and decode.
  wire logic [7:0] byteIn = {shift_ff, mosi};
  wire logic byteDone = (bitCnt_ff == rdr_pkg::LAST_BIT);
  wire logic [4:0] addrNext = cont_ff ? 5'(addr_ff + 5'h01) : addr_ff;
  wire logic isCmdWord = byteIn[rdr_pkg::BIT_CTL];
  wire logic isRdWord = byteIn[rdr_pkg::BIT_RD];
  wire logic isContWord = byteIn[rdr_pkg::BIT_CONT];
  wire logic [4:0] wordCode = byteIn[4:0];

  // Shifter and transaction state, cleared asynchronously while slave-select is high.
  always_ff @(posedge sclkFall or posedge ssN) begin
    if (ssN) begin
      bitCnt_ff <= 3'h0;
      shift_ff <= 7'h00;
      phase_ff <= rdr_pkg::PH_ADDR;
      addr_ff <= 5'h00;
      rdMode_ff <= 1'b0;
      cont_ff <= 1'b0;
      txShift_ff <= 8'h00;
      misoOe <= 1'b0;
    end else begin
      bitCnt_ff <= 3'(bitCnt_ff + 3'h1);
      shift_ff <= byteIn[6:0];
      txShift_ff <= {txShift_ff[6:0], 1'b0};
      if (byteDone) begin
        case (phase_ff)
          rdr_pkg::PH_ADDR: begin
            phase_ff <= isCmdWord ? rdr_pkg::PH_HOLD : rdr_pkg::PH_DATA;
            addr_ff <= wordCode;
            rdMode_ff <= ~isCmdWord & isRdWord;
            cont_ff <= ~isCmdWord & isContWord;
            if (~isCmdWord & isRdWord) begin
              txShift_ff <= readReg(snapLink, wordCode);
              misoOe <= 1'b1;
            end
          end
          rdr_pkg::PH_DATA: begin
            addr_ff <= addrNext;
            if (rdMode_ff) begin
              txShift_ff <= readReg(snapLink, addrNext);
            end
          end
          default: begin
            phase_ff <= rdr_pkg::PH_HOLD;
          end
        endcase
      end
    end
  end
  assign misoOut = txShift_ff[7];

  // Event to the system side; dropped if the previous one is still in flight.
  wire logic evFire = byteDone & ~ssN & (phase_ff != rdr_pkg::PH_HOLD)
                      & ((phase_ff == rdr_pkg::PH_DATA) | isCmdWord | isRdWord);
  wire rdr_pkg::rdr_evk_t evKind = (phase_ff == rdr_pkg::PH_ADDR)
      ? (isCmdWord ? rdr_pkg::EV_CMD : rdr_pkg::EV_RD)
      : (rdMode_ff ? rdr_pkg::EV_RD : rdr_pkg::EV_WR);
  wire logic [4:0] evAddr = (phase_ff == rdr_pkg::PH_ADDR) ? wordCode
      : (rdMode_ff ? addrNext : addr_ff);
  // The crossing latches the event on the edge that completes the byte, so the last
  // byte of a frame never waits for a link clock that may not come before the stop.
  wire rdr_pkg::rdr_evt_t evNow = {evKind, evAddr, byteIn};

  // System domain from here on.
  logic sysEvValid;
  rdr_pkg::rdr_evt_t sysEv;
  rdr_pkg::rdr_evt_t sysEvRaw;
  rdr_pkg::rdr_snap_t snapOut;
  logic snapReady;
  rdr_pkg::rdr_snap_t snapSent_ff;
  logic [7:0] chip_ff;
  logic [7:0] iso_ff;
  logic [7:0] modr_ff;
  logic [7:0] irq_ff;
  logic irqClrArm_ff;
  logic [7:0] fifoMem [DEPTH];
  logic [6:0] wrPtr_ff;
  logic [6:0] rdPtr_ff;
  logic [6:0] cnt_ff;
  logic ssPrev_ff;
  logic [3:0] pinS;

  rdr_hs_xfer #(.W($bits(rdr_pkg::rdr_evt_t))) uEvX (
    .srcClk(sclkFall), .srcRst(linkRst), .srcValid(evFire), .srcData(evNow),
    .srcReady(evReady), .dstClk(clock), .dstRst(rst), .dstValid(sysEvValid),
    .dstData(sysEvRaw)
  );
  rdr_hs_xfer #(.W($bits(rdr_pkg::rdr_snap_t))) uSnapX (
    .srcClk(clock), .srcRst(rst), .srcValid(snapOut != snapSent_ff), .srcData(snapOut),
    .srcReady(snapReady), .dstClk(sclkFall), .dstRst(linkRst), .dstValid(snapValid),
    .dstData(snapLink)
  );
  rdr_sync2 #(.W(4)) uPins (
    .clock(clock), .rst(rst),
    .din({~ssN, modulationInputPin, subcarrierIn, modulationTypeSelect}),
    .dout(pinS)
  );
  assign sysEv = sysEvRaw;

  // Mode decode and event qualification.
  wire logic ssS = ~pinS[3]; // Synced inverted so the reset value matches the idle pin.
  wire logic modPinS = pinS[2];
  wire logic subS = pinS[1];
  wire logic modTypeS = pinS[0];
  wire logic ssRise = ssS & ~ssPrev_ff;
  wire logic direct = chip_ff[rdr_pkg::DIRECT_BIT];
  wire logic dm0 = direct & ~iso_ff[rdr_pkg::ISO_DM_BIT];
  wire logic dm1 = direct & iso_ff[rdr_pkg::ISO_DM_BIT];
  // Both direct modes ignore serial events; the entry clocks would otherwise write.
  wire logic accept = sysEvValid & ~direct;

  function automatic logic evHit(input logic ok, input rdr_pkg::rdr_evt_t e,
                                 input rdr_pkg::rdr_evk_t k, input logic [4:0] a);
    evHit = ok & (e.kind == k) & (e.addr == a);
  endfunction

  wire logic wrChip = evHit(accept, sysEv, rdr_pkg::EV_WR, rdr_pkg::ADR_CHIP);
  wire logic wrIso = evHit(accept, sysEv, rdr_pkg::EV_WR, rdr_pkg::ADR_ISO);
  wire logic wrModr = evHit(accept, sysEv, rdr_pkg::EV_WR, rdr_pkg::ADR_MODR);
  wire logic rdIrq = evHit(accept, sysEv, rdr_pkg::EV_RD, rdr_pkg::ADR_IRQ);
  wire logic fifoRst = evHit(accept, sysEv, rdr_pkg::EV_CMD, rdr_pkg::CMD_FIFO_RST);
  wire logic anyRd = accept & (sysEv.kind == rdr_pkg::EV_RD);
  wire logic spiPush = evHit(accept, sysEv, rdr_pkg::EV_WR, rdr_pkg::ADR_FIFO);
  wire logic rxPush = rxByteValid & ~direct;
  wire logic fifoFull = (cnt_ff == 7'(DEPTH));
  wire logic doPush = (spiPush | rxPush) & ~fifoFull & ~fifoRst;
  wire logic [7:0] pushByte = rxPush ? rxByte : sysEv.data;
  wire logic doPop = evHit(accept, sysEv, rdr_pkg::EV_RD, rdr_pkg::ADR_FIFO)
                     & (cnt_ff != rdr_pkg::RST_CNT) & ~fifoRst;
  wire logic [6:0] wrPtrInc = (wrPtr_ff == 7'(DEPTH - 1)) ? 7'h00 : 7'(wrPtr_ff + 7'h01);
  wire logic [6:0] rdPtrInc = (rdPtr_ff == 7'(DEPTH - 1)) ? 7'h00 : 7'(rdPtr_ff + 7'h01);
  // An empty FIFO reads as zero, which keeps unwritten storage out of the snapshot.
  wire logic [7:0] fifoHead = (cnt_ff == rdr_pkg::RST_CNT) ? 8'h00 : fifoMem[rdPtr_ff];
  assign snapOut = '{chip: chip_ff, iso: iso_ff, modr: modr_ff, irq: irq_ff,
                     fcnt: cnt_ff, fhead: fifoHead};

  // Control registers; a stop always beats a write of the direct bit.
  always_ff @(posedge clock) begin
    if (rst) begin
      chip_ff <= rdr_pkg::RST_REG;
      iso_ff <= rdr_pkg::RST_REG;
      modr_ff <= rdr_pkg::RST_REG;
      ssPrev_ff <= 1'b1;
      snapSent_ff <= '0;
    end else begin
      ssPrev_ff <= ssS;
      if (ssRise) begin
        chip_ff[rdr_pkg::DIRECT_BIT] <= 1'b0;
      end else if (wrChip) begin
        chip_ff <= sysEv.data;
      end
      if (wrIso) begin
        iso_ff <= sysEv.data;
      end
      if (wrModr) begin
        modr_ff <= sysEv.data;
      end
      if (snapReady) begin
        snapSent_ff <= snapOut;
      end
    end
  end

  // Interrupt status: a new tx done wins over the clear made by the dummy read.
  wire logic irqSet = txDoneIn & ~dm0;
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_ff <= rdr_pkg::RST_REG;
      irqClrArm_ff <= 1'b0;
      irqOut <= 1'b0;
    end else begin
      if (anyRd) begin
        irqClrArm_ff <= rdIrq;
      end
      if (anyRd & irqClrArm_ff) begin
        irq_ff <= rdr_pkg::RST_REG;
      end
      if (irqSet) begin
        irq_ff[rdr_pkg::IRQ_TX_BIT] <= 1'b1;
      end
      irqOut <= (|irq_ff) & ~dm0;
    end
  end

  // FIFO pointers and count; storage is a flop array addressed by the pointers.
  always_ff @(posedge clock) begin
    if (rst | fifoRst) begin
      wrPtr_ff <= rdr_pkg::RST_CNT;
      rdPtr_ff <= rdr_pkg::RST_CNT;
      cnt_ff <= rdr_pkg::RST_CNT;
    end else begin
      if (doPush) begin
        wrPtr_ff <= wrPtrInc;
      end
      if (doPop) begin
        rdPtr_ff <= rdPtrInc;
      end
      cnt_ff <= 7'(cnt_ff + {6'h00, doPush} - {6'h00, doPop});
    end
  end

  // Storage holds no reset; unread locations are never observed.
  always_ff @(posedge clock) begin
    if (doPush) begin
      fifoMem[wrPtr_ff] <= pushByte;
    end
  end

  // Pin-facing outputs for the direct modes.
  always_ff @(posedge clock) begin
    if (rst) begin
      modDrive <= 1'b0;
      rxDataOut <= 1'b0;
      bitClkOut <= 1'b0;
      modTypeOut <= 1'b0;
      directActive <= 1'b0;
      fifoCount <= rdr_pkg::RST_CNT;
    end else begin
      modDrive <= direct ? modPinS : protoModIn;
      rxDataOut <= dm0 ? subS : (dm1 & decBitIn);
      bitClkOut <= dm1 & decClkIn;
      modTypeOut <= modTypeS;
      directActive <= direct;
      fifoCount <= cnt_ff;
    end
  end

  // Checks in the system domain.
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence stopSeen;
    $rose(ssS);
  endsequence
  chk_stop_exit_direct: assert property (stopSeen |=> !chip_ff[rdr_pkg::DIRECT_BIT])
    else $error("Direct bit survived a stop.");
  chk_direct_entry_now: assert property (wrChip && !ssRise |=> direct == sysEv.data[6])
    else $error("Direct bit write not taken at once.");
  chk_dm0_mod_path: assert property (dm0 ##1 dm0 |-> modDrive == $past(modPinS))
    else $error("Modulation not following the pin in mode 0.");
  chk_dm1_bit_clock: assert property (dm1 |=> bitClkOut == $past(decClkIn))
    else $error("Bit clock not passed in mode 1.");
  chk_txdone_irq_set: assert property (irqSet |=> irq_ff[7] ##1 irqOut || !$past(dm0))
    else $error("Tx done did not raise the interrupt.");
  chk_fifo_reset_clear: assert property (fifoRst |=> cnt_ff == rdr_pkg::RST_CNT
    ##1 fifoCount == rdr_pkg::RST_CNT)
    else $error("FIFO reset left bytes behind.");
  chk_dm0_irq_quiet: assert property (dm0 ##1 dm0 |=> !irqOut)
    else $error("Interrupt raised in mode 0.");
  chk_fifo_depth_bound: assert property (cnt_ff <= 7'(DEPTH))
    else $error("FIFO count beyond its depth.");

  // Checks in the link domain.
  chk_word_bit_wrap: assert property (@(posedge sclkFall) disable iff (ssN)
    byteDone |=> bitCnt_ff == 3'h0)
    else $error("Word is not eight bits long.");
  chk_miso_msb_order: assert property (@(posedge sclkFall) disable iff (ssN)
    !byteDone |=> misoOut == $past(txShift_ff[6]))
    else $error("Read byte not shifted MSB first.");
endmodule
`default_nettype wire

// File: rdr_pkg.sv
// Shared constants and types for the reader serial port and direct-mode block.
// Assumes both clock domains of the block use these definitions unchanged.
package rdr_pkg;
  // Register word addresses on the serial link.
  localparam logic [4:0] ADR_CHIP = 5'h00;
  localparam logic [4:0] ADR_ISO = 5'h01;
  localparam logic [4:0] ADR_MODR = 5'h09;
  localparam logic [4:0] ADR_IRQ = 5'h0C;
  localparam logic [4:0] ADR_FSTAT = 5'h1C;
  localparam logic [4:0] ADR_FIFO = 5'h1F;
  // Command code that empties the FIFO.
  localparam logic [4:0] CMD_FIFO_RST = 5'h0F;
  // Field positions of the address or command word.
  localparam int BIT_CTL = 7;
  localparam int BIT_RD = 6;
  localparam int BIT_CONT = 5;
  // Field positions inside registers.
  localparam int DIRECT_BIT = 6;
  localparam int ISO_DM_BIT = 6;
  localparam int IRQ_TX_BIT = 7;
  // Reset values.
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [6:0] RST_CNT = 7'h00;
  // Word length and FIFO depth.
  localparam int WORD_BITS = 8;
  localparam int FIFO_DEPTH = 127;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Kind of event the link hands to the system side.
  typedef enum logic [1:0] {EV_WR, EV_RD, EV_CMD} rdr_evk_t;
  // Phase of a serial transaction.
  typedef enum logic [1:0] {PH_ADDR, PH_DATA, PH_HOLD} rdr_ph_t;

  // One decoded byte event from the link.
  typedef struct packed {
    rdr_evk_t kind;
    logic [4:0] addr;
    logic [7:0] data;
  } rdr_evt_t;

  // Readable state published to the link domain.
  typedef struct packed {
    logic [7:0] chip;
    logic [7:0] iso;
    logic [7:0] modr;
    logic [7:0] irq;
    logic [6:0] fcnt;
    logic [7:0] fhead;
  } rdr_snap_t;
endpackage

// File: rdr_sync2.sv
// Two-flop level synchroniser, one stage pair per bit.
// Assumes the inputs are levels that stay put for at least two destination edges.
`timescale 1ns/1ns
`default_nettype none
module rdr_sync2 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= '0;
      dout <= '0;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// File: rdr_hs_xfer.sv
// Toggle handshake that carries one word from a source domain to a destination.
// Assumes the source waits for srcReady before offering the next word.
`timescale 1ns/1ns
`default_nettype none
module rdr_hs_xfer #(
  parameter int W = 8
) (
  input wire logic srcClk,
  input wire logic srcRst,
  input wire logic srcValid,
  input wire logic [W-1:0] srcData,
  output logic srcReady,
  input wire logic dstClk,
  input wire logic dstRst,
  output logic dstValid,
  output logic [W-1:0] dstData
);
  logic req_ff;
  logic [W-1:0] hold_ff;
  logic ack_ff;
  logic ackS;
  logic reqS;
  logic seen_ff;
  wire logic take = srcValid & srcReady;

  // The word is held still until the far side acknowledges it.
  always_ff @(posedge srcClk) begin
    if (srcRst) begin
      req_ff <= 1'b0;
      hold_ff <= '0;
    end else if (take) begin
      req_ff <= ~req_ff;
      hold_ff <= srcData;
    end
  end
  assign srcReady = (req_ff == ackS);

  rdr_sync2 #(.W(1)) uAck (.clock(srcClk), .rst(srcRst), .din(ack_ff), .dout(ackS));
  rdr_sync2 #(.W(1)) uReq (.clock(dstClk), .rst(dstRst), .din(req_ff), .dout(reqS));

  // A changed request level marks a new word; capture it and echo the level back.
  always_ff @(posedge dstClk) begin
    if (dstRst) begin
      seen_ff <= 1'b0;
      ack_ff <= 1'b0;
      dstValid <= 1'b0;
      dstData <= '0;
    end else begin
      dstValid <= (reqS != seen_ff);
      seen_ff <= reqS;
      ack_ff <= seen_ff;
      if (reqS != seen_ff) begin
        dstData <= hold_ff;
      end
    end
  end
endmodule
`default_nettype wire

// File: rdr_spi_master_model.sv
// Behavioural serial master that plays the microcontroller on the link.
// Assumes the bench calls its tasks one at a time; sclk idles low.
`timescale 1ns/1ns
`default_nettype none
module rdr_spi_master_model (
  output logic sclk,
  output logic ssN,
  output logic mosi,
  input wire logic miso
);
  localparam int HALF = 6;

  // Idle levels: deselected and the link clock standing still.
  initial begin
    sclk = 1'b0;
    ssN = 1'b1;
    mosi = 1'b0;
  end

  // Clocks with select high let the link side see the synced reset.
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
    end
  endtask

  task automatic start();
    #HALF ssN = 1'b0;
  endtask

  // A released data line shows the inverse of its last value, never a stale one.
  task automatic stop();
    #HALF ssN = 1'b1;
    mosi = ~mosi;
    #HALF;
  endtask

  // Shifts n bits MSB first; miso is taken before the falling edge moves it.
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      #HALF sclk = 1'b1;
      mosi = tx[i];
      rx[i] = miso;
      #HALF sclk = 1'b0;
    end
    // The gap keeps byte events far enough apart to cross domains.
    #40;
  endtask

  // Write data is not captured by callers, since miso is invalid then.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    shift(tx, 8, rx);
  endtask
endmodule
`default_nettype wire

// File: rdr_spi_direct_bench.sv
// Self-checking bench for the serial port and direct-mode block.
// Assumes the master model drives the link and the bench drives the rest.
`timescale 1ns/1ns
`default_nettype none
module rdr_spi_direct_bench;
  logic clock, rst, sclk, ssN, mosi, misoOut, misoOe;
  logic modulationInputPin, modulationTypeSelect, subcarrierIn, decBitIn, decClkIn;
  logic protoModIn, txDoneIn, rxByteValid, modDrive, modTypeOut, rxDataOut;
  logic bitClkOut, irqOut, directActive;
  logic [7:0] rxByte, d;
  logic [6:0] fifoCount;
  int n_mismatch, tests_run;

  rdr_spi_master_model m (.sclk(sclk), .ssN(ssN), .mosi(mosi), .miso(misoOut));

  rdr_spi_direct #(.DEPTH(127)) uut (.clock(clock), .rst(rst), .sclk(sclk), .ssN(ssN),
    .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe),
    .modulationInputPin(modulationInputPin), .modulationTypeSelect(modulationTypeSelect),
    .subcarrierIn(subcarrierIn), .decBitIn(decBitIn), .decClkIn(decClkIn),
    .protoModIn(protoModIn), .txDoneIn(txDoneIn), .rxByteValid(rxByteValid),
    .rxByte(rxByte), .modDrive(modDrive), .modTypeOut(modTypeOut), .rxDataOut(rxDataOut),
    .bitClkOut(bitClkOut), .irqOut(irqOut), .directActive(directActive),
    .fifoCount(fifoCount));

  // System clock at 100 MHz.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic summarize();
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic sig(input int k);
    sig = (k == 0) ? directActive : (k == 1) ? irqOut : (fifoCount === 7'h00);
  endfunction

  // Bounded wait on a status output; running out ends the run at once.
  task automatic wait_for(input int k, input logic v);
    int i;
    i = 0;
    while (sig(k) !== v && i < 100) begin
      @(negedge clock);
      i++;
    end
    chk($sformatf("status %0d", k), {7'h00, v}, {7'h00, sig(k)});
    if (sig(k) !== v) summarize();
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] dat);
    m.start();
    m.xfer({3'b000, a}, d);
    m.xfer(dat, d);
    m.stop();
  endtask

  // An idle command keeps sclk running so the readable snapshot catches up.
  task automatic rdchk(input string nm, input logic [4:0] a, input logic [7:0] exp);
    m.start();
    m.xfer(8'h80, d);
    m.xfer(8'h00, d);
    m.stop();
    m.start();
    m.xfer({3'b010, a}, d);
    chk("misoOe", 8'h01, {7'h00, misoOe});
    m.xfer(8'h00, d);
    chk(nm, exp, d);
    m.stop();
    chk("misoOe off", 8'h00, {7'h00, misoOe});
  endtask

  // Enters direct mode with the select write left open, plus eight clocks.
  task automatic enter_direct(input logic [7:0] iso);
    wr(5'h09, 8'h61);
    wr(5'h01, iso);
    m.start();
    m.xfer(8'h00, d);
    m.xfer(8'h40, d);
    m.shift(8'h00, 8, d);
    wait_for(0, 1'b1);
  endtask

  initial begin
    logic [7:0] isoCodes [4];
    isoCodes = '{8'h02, 8'h08, 8'h1A, 8'h1B};
    n_mismatch = 0;
    tests_run = 0;
    {modulationInputPin, subcarrierIn, decBitIn, decClkIn, protoModIn} = 5'h00;
    {txDoneIn, rxByteValid} = 2'h0;
    modulationTypeSelect = 1'b1;
    rxByte = 8'h00;
    rst = 1'b1;
    m.idle_clocks(4);
    repeat (12) @(negedge clock);
    rst = 1'b0;
    m.idle_clocks(4);
    chk("reset outputs", 8'h00, {4'h0, directActive, irqOut, misoOe, |fifoCount});
    chk("reset pins", 8'h00, {5'h00, modDrive, rxDataOut, bitClkOut});
    // Outside direct mode the modulator follows the protocol engine.
    @(negedge clock) protoModIn = 1'b1;
    repeat (2) @(negedge clock);
    chk("modDrive proto", 8'h01, {7'h00, modDrive});
    protoModIn = 1'b0;
    $display("test reset done");

    // Protocol and modulator codes written and read back.
    foreach (isoCodes[k]) begin
      wr(5'h01, isoCodes[k]);
      rdchk("iso", 5'h01, isoCodes[k]);
    end
    for (int k = 0; k < 6; k++) begin
      wr(5'h09, 8'h20 + 8'(k));
      rdchk("modr", 5'h09, 8'h20 + 8'(k));
    end
    rdchk("unmapped", 5'h02, 8'h00);
    $display("test registers done");

    // A torn word must not shift the bit count of the next frame.
    m.start();
    m.shift(8'hFF, 4, d);
    m.stop();
    wr(5'h01, 8'h1A);
    rdchk("after torn", 5'h01, 8'h1A);
    $display("test torn word done");

    // Transmit done, status read, dummy read clears it.
    @(negedge clock) txDoneIn = 1'b1;
    @(negedge clock) txDoneIn = 1'b0;
    wait_for(1, 1'b1);
    m.start();
    m.xfer(8'h6C, d);
    m.xfer(8'h00, d);
    chk("irq status", 8'h80, d);
    m.xfer(8'h00, d);
    m.stop();
    wait_for(1, 1'b0);
    $display("test irq done");

    // Framed data bytes fill the FIFO; the reset command empties it.
    for (int k = 0; k < 3; k++) begin
      @(negedge clock) rxByteValid = 1'b1;
      rxByte = 8'hA5 ^ 8'(k);
      @(negedge clock) rxByteValid = 1'b0;
    end
    repeat (2) @(negedge clock);
    chk("fifoCount", 8'h03, {1'b0, fifoCount});
    rdchk("fifo status", 5'h1C, 8'h03);
    rdchk("fifo head", 5'h1F, 8'hA5);
    m.start();
    m.xfer(8'h8F, d);
    m.stop();
    wait_for(2, 1'b1);
    $display("test fifo done");

    // Direct mode 0: pins pass straight through; host services are off.
    enter_direct(8'h08);
    for (int v = 0; v < 2; v++) begin
      @(negedge clock) modulationInputPin = ~v[0];
      subcarrierIn = v[0];
      repeat (6) @(negedge clock);
      chk("modDrive", {7'h00, ~v[0]}, {7'h00, modDrive});
      chk("rxDataOut", {7'h00, v[0]}, {7'h00, rxDataOut});
    end
    chk("modTypeOut", 8'h01, {7'h00, modTypeOut});
    @(negedge clock) txDoneIn = 1'b1;
    rxByteValid = 1'b1;
    @(negedge clock) txDoneIn = 1'b0;
    rxByteValid = 1'b0;
    repeat (10) @(negedge clock);
    chk("direct irq", 8'h00, {7'h00, irqOut});
    chk("direct fifo", 8'h00, {1'b0, fifoCount});
    m.stop();
    wait_for(0, 1'b0);
    rdchk("chip after stop", 5'h00, 8'h00);
    $display("test direct mode 0 done");

    // Direct mode 1: decoded bit and bit clock on the pins.
    enter_direct(8'h48);
    for (int v = 0; v < 2; v++) begin
      @(negedge clock) decBitIn = v[0];
      decClkIn = ~v[0];
      modulationInputPin = v[0];
      repeat (6) @(negedge clock);
      chk("rxDataOut dec", {7'h00, v[0]}, {7'h00, rxDataOut});
      chk("bitClkOut", {7'h00, ~v[0]}, {7'h00, bitClkOut});
      chk("modDrive dm1", {7'h00, v[0]}, {7'h00, modDrive});
    end
    m.stop();
    wait_for(0, 1'b0);
    $display("test direct mode 1 done");
    summarize();
  end
endmodule
`default_nettype wire
